// file: hdl/isa_pkg.sv
// Package for the two-wire slave receiver: field positions, mode codes, timing and carriers.
// Assumes a single 50 MHz core clock.
package isa_pkg;

  // ****************************************
  // Control, status and flag field positions
  // ****************************************
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_MODE_MSB = 3;
  localparam int unsigned CTL_EN_BIT = 5;
  localparam int unsigned CTL_OV_BIT = 6;
  localparam int unsigned STS_BF_BIT = 0;
  localparam int unsigned STS_UA_BIT = 1;
  localparam int unsigned STS_RW_BIT = 2;
  localparam int unsigned STS_START_BIT = 3;
  localparam int unsigned STS_STOP_BIT = 4;
  localparam int unsigned STS_DA_BIT = 5;
  localparam int unsigned PFR_IRQ_BIT = 3;

  // ****************************************
  // Mode codes and constants
  // ****************************************
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [4:0] HDR10_PREFIX = 5'h1e;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  localparam int unsigned FILT_LEN = 3;

  typedef struct packed {
    logic stop_seen;
    logic start_seen;
    logic data_not_addr;
    logic read_not_write;
    logic update_addr;
    logic buf_full;
  } isa_status_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } isa_pin_drive_t;

endpackage

// file: hdl/isa_glitch_filter.sv
// Glitch filter for one bus line: the output moves only after FILT_LEN equal samples.
// Assumes the pin input is already synchronous to core_clk.
`timescale 1ns/100ps
module isa_glitch_filter
  import isa_pkg::*;
#(
  parameter int unsigned LEN = FILT_LEN
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin_i,
  output logic line_q
);
  logic [LEN-1:0] hist_q;

  // A history shorter than two samples cannot tell a glitch from a level.
  if (LEN < 2) begin : g_len_check
    $error("filter length too short");
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hist_q <= '1;
    end else begin
      hist_q <= {hist_q[LEN-2:0], pin_i};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      line_q <= 1'b1;
    end else if (&hist_q) begin
      line_q <= 1'b1;
    end else if (~|hist_q) begin
      line_q <= 1'b0;
    end
  end
endmodule // isa_glitch_filter

// file: hdl/isa_clk_div.sv
// Enable-pulse divider for master clock rate: pulse every 4*(div+1) core cycles.
// Assumes div_val is steady while running.
`timescale 1ns/100ps
module isa_clk_div (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [7:0] div_val,
  output logic tick_q
);
  logic [9:0] cnt_q;
  logic [9:0] limit;

  assign limit = {div_val, 2'b00} + 10'h003;

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      cnt_q <= 10'h000;
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 10'h000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 10'h001;
      tick_q <= 1'b0;
    end
  end
endmodule // isa_clk_div

// file: hdl/isa_slave.sv
// Slave receiver of the two-wire port, with register bits as plain ports.
// Assumes core_clk far faster than the bus clock and synchronous pin inputs.
`timescale 1ns/100ps
module isa_slave
  import isa_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output isa_pin_drive_t pin_q,
  input wire logic [7:0] ctl_wr_data,
  input wire logic ctl_wr,
  input wire logic [7:0] addr_wr_data,
  input wire logic addr_wr,
  input wire logic buf_rd,
  input wire logic irq_clr,
  output logic [7:0] port_control_reg,
  output logic [7:0] slave_address_reg,
  output logic [7:0] rx_tx_buffer,
  output isa_status_t port_status_reg,
  output logic port_irq_flag,
  output logic master_tick_q
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_ACK = 4'b0100,
    ST_SKIP = 4'b1000
  } isa_state_t;

  isa_state_t state_q;
  logic scl_f;
  logic sda_f;
  logic scl_d1_q;
  logic sda_d1_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic is_addr_q;
  logic hdr_done_q;
  logic low_done_q;
  logic hold_q;
  logic ack_q;
  logic irq_pend_q;
  logic enabled;
  logic is_slave;
  logic is_ten;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic eighth_fall;
  logic ninth_fall;
  logic byte_ok;
  logic addr_match;
  logic hdr_match;
  logic low_match;
  logic ov_bit;
  logic bf_bit;
  logic load_now;
  logic ack_now;
  logic ov_set;
  logic next_is_addr;

  assign enabled = port_control_reg[CTL_EN_BIT];
  assign is_ten = port_control_reg[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_SLV10;
  assign is_slave = is_ten || (port_control_reg[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_SLV7);
  assign ov_bit = port_control_reg[CTL_OV_BIT];
  assign bf_bit = port_status_reg.buf_full;

  // ****************************************
  // Input filtering, master clock divider and edge detection
  // ****************************************
  isa_glitch_filter #(.LEN(FILT_LEN)) u_scl_filt (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_i(scl_i),
    .line_q(scl_f)
  );

  isa_glitch_filter #(.LEN(FILT_LEN)) u_sda_filt (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_i(sda_i),
    .line_q(sda_f)
  );

  isa_clk_div u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(enabled && port_control_reg[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_MASTER),
    .div_val(slave_address_reg),
    .tick_q(master_tick_q)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_f;
      sda_d1_q <= sda_f;
    end
  end

  assign scl_rise = scl_f && !scl_d1_q;
  assign scl_fall = !scl_f && scl_d1_q;
  assign start_det = enabled && scl_f && scl_d1_q && !sda_f && sda_d1_q;
  assign stop_det = enabled && scl_f && scl_d1_q && sda_f && !sda_d1_q;
  assign eighth_fall = (state_q == ST_SHIFT) && scl_fall && bit_cnt_q == BITS_PER_BYTE;
  assign ninth_fall = (state_q == ST_ACK) && scl_fall;

  // ****************************************
  // Address decode
  // ****************************************
  assign hdr_match = shift_q[7:3] == HDR10_PREFIX
    && shift_q[7:1] == slave_address_reg[7:1] && !shift_q[0];
  assign low_match = shift_q == slave_address_reg;
  // In ten-bit mode the address register holds whichever half is expected next.
  always_comb begin
    if (!is_ten) begin
      addr_match = shift_q[7:1] == slave_address_reg[7:1];
    end else if (!hdr_done_q) begin
      addr_match = hdr_match;
    end else if (!low_done_q) begin
      addr_match = low_match;
    end else begin
      // After a repeated start only the header half is compared again.
      addr_match = hdr_match;
    end
  end

  // Data bytes always count; an address byte counts only on a match.
  assign byte_ok = is_addr_q ? addr_match : 1'b1;
  assign load_now = eighth_fall && byte_ok && !bf_bit;
  assign ack_now = eighth_fall && byte_ok && !bf_bit && !ov_bit;
  assign ov_set = eighth_fall && byte_ok && (bf_bit || (!is_addr_q && bf_bit));
  // Only a matched write header is followed by a second address byte.
  assign next_is_addr = is_ten && is_addr_q && !shift_q[0] && hdr_done_q && !low_done_q;

  // ****************************************
  // Bus sequencing
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst || !enabled || !is_slave) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      is_addr_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_SHIFT;
      bit_cnt_q <= 4'h0;
      is_addr_q <= 1'b1;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          bit_cnt_q <= 4'h0;
        end
        ST_SHIFT: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (eighth_fall) begin
            state_q <= byte_ok ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (ninth_fall) begin
            state_q <= (is_addr_q && shift_q[0]) ? ST_SKIP : ST_SHIFT;
            bit_cnt_q <= 4'h0;
            is_addr_q <= next_is_addr;
          end
        end
        ST_SKIP: begin
          bit_cnt_q <= 4'h0;
        end
      endcase
    end
  end

  // Ten-bit address progress; a repeated start keeps the low half as matched.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !enabled || stop_det) begin
      hdr_done_q <= 1'b0;
      low_done_q <= 1'b0;
    end else if (eighth_fall && is_addr_q && is_ten && addr_match) begin
      if (!hdr_done_q) begin
        hdr_done_q <= 1'b1;
      end else if (!low_done_q) begin
        low_done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // The acknowledge stands from the eighth falling clock edge to the ninth.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !enabled) begin
      ack_q <= 1'b0;
    end else if (ack_now) begin
      ack_q <= 1'b1;
    end else if (ninth_fall || start_det || stop_det) begin
      ack_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !enabled) begin
      hold_q <= 1'b0;
    end else if (ninth_fall && ack_q && port_status_reg.update_addr) begin
      // Both address halves stretch the clock until software swaps the address.
      hold_q <= 1'b1;
    end else if (addr_wr) begin
      hold_q <= 1'b0;
    end
  end

  // Open-drain drive: an enable pulls its line low, so the data value stays zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_q <= '0;
    end else begin
      pin_q.sda_o <= 1'b0;
      pin_q.sda_oe <= enabled && ack_q;
      pin_q.scl_o <= 1'b0;
      pin_q.scl_oe <= enabled && hold_q;
    end
  end

  // ****************************************
  // Software-facing registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_control_reg <= CTL_RESET;
    end else begin
      if (ctl_wr) begin
        port_control_reg <= ctl_wr_data;
      end
      if (ov_set) begin
        port_control_reg[CTL_OV_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slave_address_reg <= ADDR_RESET;
    end else if (addr_wr) begin
      slave_address_reg <= addr_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_tx_buffer <= 8'h00;
    end else if (load_now) begin
      rx_tx_buffer <= shift_q;
    end
  end

  // Status bits are cleared whenever the port is switched off.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !enabled) begin
      port_status_reg <= '0;
    end else begin
      if (buf_rd) begin
        port_status_reg.buf_full <= 1'b0;
      end
      if (load_now) begin
        port_status_reg.buf_full <= 1'b1;
        port_status_reg.data_not_addr <= !is_addr_q;
        if (is_addr_q) begin
          port_status_reg.read_not_write <= shift_q[0];
        end
      end
      if (addr_wr) begin
        port_status_reg.update_addr <= 1'b0;
      end
      if (ack_now && is_ten && is_addr_q && !low_done_q) begin
        port_status_reg.update_addr <= 1'b1;
      end
      if (start_det) begin
        port_status_reg.start_seen <= 1'b1;
        port_status_reg.stop_seen <= 1'b0;
      end
      if (stop_det) begin
        port_status_reg.stop_seen <= 1'b1;
        port_status_reg.start_seen <= 1'b0;
      end
    end
  end

  // Flag rises at the ninth falling edge; a set beats a simultaneous clear.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_pend_q <= 1'b0;
      port_irq_flag <= 1'b0;
    end else begin
      if (eighth_fall && byte_ok) begin
        irq_pend_q <= 1'b1;
      end else if (ninth_fall) begin
        irq_pend_q <= 1'b0;
      end
      if (ninth_fall && irq_pend_q) begin
        port_irq_flag <= 1'b1;
      end else if (irq_clr) begin
        port_irq_flag <= 1'b0;
      end
    end
  end

endmodule // isa_slave

// file: test/isa_slave_assertions.sv
// Checker for the two-wire slave receiver ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module isa_slave_chk
  import isa_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire isa_pin_drive_t pin_q,
  input wire logic [7:0] ctl_wr_data,
  input wire logic ctl_wr,
  input wire logic [7:0] addr_wr_data,
  input wire logic addr_wr,
  input wire logic buf_rd,
  input wire logic irq_clr,
  input wire logic [7:0] port_control_reg,
  input wire logic [7:0] slave_address_reg,
  input wire logic [7:0] rx_tx_buffer,
  input wire isa_status_t port_status_reg,
  input wire logic port_irq_flag,
  input wire logic master_tick_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_ack_up;
    $rose(pin_q.sda_oe);
  endsequence
  property p_off;
    !port_control_reg[CTL_EN_BIT] && !$past(port_control_reg[CTL_EN_BIT])
      |-> !pin_q.sda_oe && !pin_q.scl_oe;
  endproperty
  property p_ack_len;
    s_ack_up |-> pin_q.sda_oe[*8];
  endproperty
  property p_ack_irq;
    s_ack_up |-> ##[1:200] port_irq_flag;
  endproperty
  property p_ack_scl;
    $fell(pin_q.sda_oe) |-> !scl_i;
  endproperty
  property p_rd;
    buf_rd |=> !port_status_reg.buf_full;
  endproperty
  property p_ov_fall;
    $fell(port_control_reg[CTL_OV_BIT]) |-> $past(ctl_wr);
  endproperty
  property p_ov_rise;
    $rose(port_control_reg[CTL_OV_BIT]) && !$past(ctl_wr) |-> $past(port_status_reg.buf_full);
  endproperty
  property p_keep;
    $changed(rx_tx_buffer) |-> !$past(port_status_reg.buf_full);
  endproperty
  property p_irq_fall;
    $fell(port_irq_flag) |-> $past(irq_clr);
  endproperty
  property p_hold;
    $rose(pin_q.scl_oe) |-> ##[0:2] port_status_reg.update_addr;
  endproperty
  property p_rel;
    addr_wr |-> ##[1:3] !(pin_q.scl_oe || port_status_reg.update_addr);
  endproperty
  a_off: assert property (p_off) else $error("bus driven while off");
  a_ack_len: assert property (p_ack_len) else $error("ack too short");
  a_ack_irq: assert property (p_ack_irq) else $error("no flag after ack");
  a_ack_scl: assert property (p_ack_scl) else $error("ack released in clock high");
  a_rd: assert property (p_rd) else $error("read left buffer full");
  a_ov_fall: assert property (p_ov_fall) else $error("overflow fell alone");
  a_ov_rise: assert property (p_ov_rise) else $error("overflow without full");
  a_keep: assert property (p_keep) else $error("full buffer overwritten");
  a_irq_fall: assert property (p_irq_fall) else $error("flag fell alone");
  a_hold: assert property (p_hold) else $error("hold without update");
  a_rel: assert property (p_rel) else $error("hold not released");
endmodule // isa_slave_chk
bind isa_slave isa_slave_chk u_chk (.core_clk, .sys_rst, .scl_i, .sda_i, .pin_q,
  .ctl_wr_data, .ctl_wr, .addr_wr_data, .addr_wr, .buf_rd, .irq_clr, .port_control_reg,
  .slave_address_reg, .rx_tx_buffer, .port_status_reg, .port_irq_flag, .master_tick_q);

// file: test/isa_bus_master.sv
// Behavioural two-wire bus master on open-drain lines.
// Assumes pull-ups: a released line reads high.
`timescale 1ns/100ps
module isa_bus_master (
  input wire logic core_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic m_scl,
  output logic m_sda
);
  int to_cnt = 0;
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Raises the clock and waits out a hold-off by the slave of up to 2000 cycles.
  task automatic hi();
    int k;
    m_scl <= 1'b1;
    wt(2);
    k = 0;
    while (!scl_i && k < 2000) begin
      wt(1);
      k++;
    end
    if (k >= 2000) to_cnt++;
    wt(10);
  endtask
  task automatic start();
    m_sda <= 1'b1;
    wt(10);
    hi();
    m_sda <= 1'b0;
    wt(10);
    m_scl <= 1'b0;
    wt(10);
  endtask
  task automatic stop();
    m_sda <= 1'b0;
    wt(10);
    hi();
    m_sda <= 1'b1;
    wt(10);
  endtask
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      m_sda <= b[i];
      wt(10);
      hi();
      m_scl <= 1'b0;
      wt(5);
    end
    m_sda <= 1'b1;
    wt(10);
    hi();
    ack = !sda_i;
    m_scl <= 1'b0;
  endtask
endmodule // isa_bus_master

// file: test/tb_top.sv
// Self-checking bench for the two-wire slave receiver.
// Assumes the bus master model and the bound checker.
`timescale 1ns/100ps
module tb_top
  import isa_pkg::*;
;
  logic core_clk, sys_rst, ctl_wr, addr_wr, buf_rd, irq_clr, irq, tick, m_scl, m_sda;
  logic [7:0] ctl_d, adr_d, ctl_q, adr_q, buf_q;
  isa_pin_drive_t pin;
  isa_status_t sts;
  wire scl_w = m_scl & !pin.scl_oe;
  wire sda_w = m_sda & !pin.sda_oe;
  int err_total = 0;
  int compares = 0;
  int m_bf = 0;
  int m_ov = 0;
  int m_buf = 0;
  int m_irq = 0;
  int gap = 0;
  int unsigned seed = 71414;
  isa_slave uut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_i(scl_w), .sda_i(sda_w),
    .pin_q(pin), .ctl_wr_data(ctl_d), .ctl_wr(ctl_wr), .addr_wr_data(adr_d),
    .addr_wr(addr_wr), .buf_rd(buf_rd), .irq_clr(irq_clr), .port_control_reg(ctl_q),
    .slave_address_reg(adr_q), .rx_tx_buffer(buf_q), .port_status_reg(sts),
    .port_irq_flag(irq), .master_tick_q(tick));
  isa_bus_master bm (.core_clk(core_clk), .scl_i(scl_w), .sda_i(sda_w), .m_scl(m_scl),
    .m_sda(m_sda));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Strobe 0 writes control, 1 address, 2 reads buffer, 3 clears the flag.
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge core_clk);
    ctl_d <= v;
    adr_d <= v;
    ctl_wr <= (k == 0);
    addr_wr <= (k == 1);
    buf_rd <= (k == 2);
    irq_clr <= (k == 3);
    @(posedge core_clk);
    {ctl_wr, addr_wr, buf_rd, irq_clr} <= 4'h0;
    repeat (2) @(posedge core_clk);
    if (k == 0) m_ov = v[CTL_OV_BIT];
    if (k == 2) m_bf = 0;
    if (k == 3) m_irq = 0;
  endtask
  task automatic rx(input logic [7:0] b, input bit hit);
    logic a;
    bm.xfer(b, a);
    if (bm.to_cnt != 0) final_report();
    bm.wt(12);
    chk(8'(a), 8'(hit && m_bf == 0 && m_ov == 0));
    if (hit) begin
      if (m_bf == 0) m_buf = b;
      else m_ov = 1;
      m_bf = 1;
      m_irq = 1;
    end
    chk(buf_q, 8'(m_buf));
    chk(8'({sts.buf_full, ctl_q[CTL_OV_BIT], irq}), 8'({m_bf[0], m_ov[0], m_irq[0]}));
  endtask
  // Waits for the next divider pulse; a missing pulse ends the run.
  task automatic wait_tick(output int n);
    n = 0;
    @(posedge core_clk);
    while (tick !== 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 1000) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic final_report();
    err_total += bm.to_cnt;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    {ctl_wr, addr_wr, buf_rd, irq_clr} = 4'h0;
    ctl_d = 8'h00;
    adr_d = 8'h00;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk(ctl_q, 8'h00);
    chk(8'(sts), 8'h00);
    bm.start();
    rx(8'hfe, 0);
    bm.stop();
    wr(0, {4'h2, MODE_SLV7});
    wr(1, 8'hff);
    rx(8'hfe, 0);
    bm.start();
    rx(8'hfe, 1);
    chk(8'({sts.read_not_write, sts.data_not_addr}), 8'h00);
    rx(rnd(), 1);
    wr(2, 8'h00);
    rx(rnd(), 1);
    wr(0, {4'h2, MODE_SLV7});
    wr(3, 8'h00);
    rx(rnd(), 1);
    chk(8'(sts.data_not_addr), 8'h01);
    wr(2, 8'h00);
    wr(3, 8'h00);
    bm.stop();
    bm.start();
    rx(8'h80, 0);
    bm.stop();
    wr(0, {4'h2, MODE_SLV10});
    wr(1, 8'hf2);
    bm.start();
    rx({HDR10_PREFIX, 3'b010}, 1);
    chk(8'({sts.update_addr, pin.scl_oe}), 8'h03);
    wr(2, 8'h00);
    wr(3, 8'h00);
    wr(1, 8'h33);
    chk(8'({sts.update_addr, pin.scl_oe}), 8'h00);
    rx(8'h33, 1);
    chk(8'({sts.update_addr, pin.scl_oe}), 8'h03);
    wr(1, 8'hf2);
    wr(2, 8'h00);
    wr(3, 8'h00);
    bm.start();
    rx(8'hf2, 1);
    chk(8'({sts.update_addr, pin.scl_oe}), 8'h00);
    bm.stop();
    wr(1, 8'h02);
    wr(0, {4'h2, MODE_MASTER});
    wait_tick(gap);
    wait_tick(gap);
    chk(8'(gap + 1), 8'(4 * (8'h02 + 1)));
    final_report();
  end
endmodule // tb_top
